// file: hw/asf_pkg.sv
package asf_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_OPERATION_MODE = 8'hd1;
  localparam logic [7:0] ADDR_STATUS_FLAGS   = 8'hd8;

  // values after reset
  localparam logic [7:0] RST_OPERATION_MODE  = 8'h08;
  localparam logic [7:0] RST_STATUS_FLAGS    = 8'h00;

  // status register field positions
  localparam int BIT_PRIMARY_READY   = 7;
  localparam int BIT_AUX_READY       = 6;
  localparam int BIT_CAL_DONE        = 5;
  localparam int BIT_MISSING_REF     = 4;
  localparam int BIT_PRIMARY_ERROR   = 3;
  localparam int BIT_AUX_ERROR       = 2;

  // mode register field positions
  localparam int BIT_PRIMARY_ENABLE  = 5;
  localparam int BIT_AUX_ENABLE      = 4;
  localparam int MODE_SEL_LSB        = 0;
  localparam int MODE_SEL_W          = 3;

  // converter mode select encodings
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_CAL_FIRST  = 3'h4;

  // bit address of status bit 0 (bit-addressable register)
  localparam logic [7:0] BITADDR_STATUS_BASE = 8'hd8;
endpackage

// file: hw/asf_flag_cell.sv
`timescale 1ns/1ns
// one sticky status flag: hardware set wins over any clear
module asf_flag_cell
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // update sources
  input  wire logic hw_set_i,
  input  wire logic ind_clr_i,
  input  wire logic sw_we_i,
  input  wire logic sw_val_i,
  // flag
  output logic      flag_o
);
  logic flag_r;
  logic flag_nxt;

  // priority: hardware set, indirect clear, software write
  always_comb
  begin
    flag_nxt = flag_r;
    if (hw_set_i)
      flag_nxt = 1'b1;
    else if (ind_clr_i)
      flag_nxt = 1'b0;
    else if (sw_we_i)
      flag_nxt = sw_val_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag_o = flag_r;
endmodule // asf_flag_cell

// file: hw/asf_status_flags.sv
`timescale 1ns/1ns
// Contract
// - primary ready, bit 7, is set when the primary converter ends a conversion or calibration.
// - primary ready is cleared by software or by a mode write that starts a calibration.
// - while the primary ready flag is set, primary results and coefficients are not updated.
// - bit 6, auxiliary ready, acts like the primary ready flag for the auxiliary converter.
// - the calibration-done flag, bit 5, is set when a calibration completes.
// - calibration-done is cleared by a mode write launching a conversion or calibration.
// - an auxiliary calibration with the temperature sensor selected never completes.
// - while a converter is active, bit 4 flags a missing or low primary reference, else clear.
// - a missing reference forces results to all ones; only the primary pair is watched.
// - primary error, bit 3, is set when the stored primary result is all zeros or all ones.
// - after a calibration, primary error also flags a failure that blocked the coefficients.
// - the primary error flag is cleared by a mode write launching a conversion or calibration.
// - bit 2, auxiliary error, acts like the primary error flag for the auxiliary converter.
module asf_status_flags
#(
  parameter int RES_W = 24
)
(
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // special function register port
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic             sfr_wr_i,
  input  wire logic [7:0]       sfr_wdata_i,
  input  wire logic             sfr_rd_i,
  output logic      [7:0]       sfr_rdata_o,
  // bit-addressed access
  input  wire logic [7:0]       bit_addr_i,
  input  wire logic             bit_wr_i,
  input  wire logic             bit_val_i,
  // primary converter events
  input  wire logic             pri_conv_done_i,
  input  wire logic             pri_cal_done_i,
  input  wire logic             pri_cal_fail_i,
  input  wire logic [RES_W-1:0] pri_raw_i,
  // auxiliary converter events
  input  wire logic             aux_conv_done_i,
  input  wire logic             aux_cal_done_i,
  input  wire logic             aux_cal_fail_i,
  input  wire logic             aux_temp_sel_i,
  input  wire logic [RES_W-1:0] aux_raw_i,
  // primary reference pair monitor
  input  wire logic             primary_reference_pair_bad_i,
  // results and coefficient write strobes
  output logic      [RES_W-1:0] pri_result_o,
  output logic      [RES_W-1:0] aux_result_o,
  output logic                  pri_coef_we_o,
  output logic                  aux_coef_we_o,
  // mode outputs
  output logic                  primary_converter_enable_o,
  output logic                  aux_converter_enable_o,
  output logic      [2:0]       converter_mode_select_o
);
  // elaboration check: saturation needs distinct all-zero and all-one codes
  if (RES_W < 2)
  begin : g_bad_res_w
    $error("asf_status_flags: RES_W must be at least 2");
  end

  // register state
  logic [7:0]       mode_r;
  logic [7:0]       mode_nxt;
  logic [7:0]       rdata_r;
  logic [7:0]       rdata_nxt;
  logic             missing_ref_r;
  logic             missing_ref_nxt;
  logic [RES_W-1:0] pri_res_r;
  logic [RES_W-1:0] pri_res_nxt;
  logic [RES_W-1:0] aux_res_r;
  logic [RES_W-1:0] aux_res_nxt;
  logic             pri_coef_we_r;
  logic             pri_coef_we_nxt;
  logic             aux_coef_we_r;
  logic             aux_coef_we_nxt;

  // decoded strobes
  logic             mode_wr;
  logic             stat_wr;
  logic [2:0]       new_mode;
  logic             launch;
  logic             cal_launch;
  logic             bit_hit;
  logic [2:0]       bit_idx;
  logic             conv_active;

  // flag outputs
  logic             primary_ready_flag;
  logic             aux_ready_flag;
  logic             cal_done_flag;
  logic             primary_error_flag;
  logic             aux_error_flag;

  // converter event qualification
  logic             pri_take;
  logic             aux_take;
  logic             aux_cal_ok;
  logic [RES_W-1:0] pri_val;
  logic [RES_W-1:0] aux_val;
  logic             pri_sat;
  logic             aux_sat;
  logic             pri_err_set;
  logic             aux_err_set;

  // per-bit software write enables and values
  logic [7:0]       sw_we;
  logic [7:0]       sw_val;

  // register decode
  always_comb
  begin
    mode_wr    = sfr_wr_i && (sfr_addr_i == asf_pkg::ADDR_OPERATION_MODE);
    stat_wr    = sfr_wr_i && (sfr_addr_i == asf_pkg::ADDR_STATUS_FLAGS);
    new_mode   = sfr_wdata_i[asf_pkg::MODE_SEL_LSB +: asf_pkg::MODE_SEL_W];
    // any non power-down mode write launches a conversion or calibration
    launch     = mode_wr && (new_mode != asf_pkg::MODE_POWER_DOWN);
    cal_launch = mode_wr && (new_mode >= asf_pkg::MODE_CAL_FIRST);
    bit_hit    = bit_wr_i && (bit_addr_i[7:3] == asf_pkg::BITADDR_STATUS_BASE[7:3]);
    bit_idx    = bit_addr_i[2:0];
    conv_active = mode_r[asf_pkg::BIT_PRIMARY_ENABLE] || mode_r[asf_pkg::BIT_AUX_ENABLE];
  end

  // byte write enables every bit, though only the ready flags take it; bit write only the addressed one
  always_comb
  begin
    sw_we  = 8'h00;
    sw_val = sfr_wdata_i;
    if (stat_wr)
      sw_we = 8'hff;
    else if (bit_hit)
    begin
      sw_we[bit_idx]  = 1'b1;
      sw_val[bit_idx] = bit_val_i;
    end
  end

  // result path: held while the ready flag is up, forced high without a reference
  always_comb
  begin
    pri_take    = pri_conv_done_i && !primary_ready_flag;
    aux_take    = aux_conv_done_i && !aux_ready_flag;
    aux_cal_ok  = aux_cal_done_i && !aux_temp_sel_i;
    pri_val     = missing_ref_r ? {RES_W{1'b1}} : pri_raw_i;
    aux_val     = missing_ref_r ? {RES_W{1'b1}} : aux_raw_i;
    pri_sat     = (pri_val == {RES_W{1'b0}}) || (pri_val == {RES_W{1'b1}});
    aux_sat     = (aux_val == {RES_W{1'b0}}) || (aux_val == {RES_W{1'b1}});
    pri_err_set = (pri_take && pri_sat)
                  || (pri_cal_done_i && pri_cal_fail_i && !primary_ready_flag);
    aux_err_set = (aux_take && aux_sat)
                  || (aux_cal_ok && aux_cal_fail_i && !aux_ready_flag);
    pri_res_nxt = pri_take ? pri_val : pri_res_r;
    aux_res_nxt = aux_take ? aux_val : aux_res_r;
    // coefficients only land when the flag is clear and nothing went wrong
    pri_coef_we_nxt = pri_cal_done_i && !pri_cal_fail_i && !primary_ready_flag;
    aux_coef_we_nxt = aux_cal_ok && !aux_cal_fail_i && !aux_ready_flag;
  end

  // mode register, reference level and read data
  always_comb
  begin
    mode_nxt = mode_r;
    if (mode_wr)
      mode_nxt = sfr_wdata_i;
    // level flag, only meaningful while a converter runs
    missing_ref_nxt = conv_active && primary_reference_pair_bad_i;
    rdata_nxt = rdata_r;
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        asf_pkg::ADDR_OPERATION_MODE: rdata_nxt = mode_r;
        asf_pkg::ADDR_STATUS_FLAGS:   rdata_nxt = {primary_ready_flag, aux_ready_flag,
                                                   cal_done_flag, missing_ref_r,
                                                   primary_error_flag, aux_error_flag,
                                                   2'h0};
        default:                      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      mode_r        <= asf_pkg::RST_OPERATION_MODE;
      rdata_r       <= 8'h00;
      missing_ref_r <= asf_pkg::RST_STATUS_FLAGS[asf_pkg::BIT_MISSING_REF];
      pri_res_r     <= {RES_W{1'b0}};
      aux_res_r     <= {RES_W{1'b0}};
      pri_coef_we_r <= 1'b0;
      aux_coef_we_r <= 1'b0;
    end
    else
    begin
      mode_r        <= mode_nxt;
      rdata_r       <= rdata_nxt;
      missing_ref_r <= missing_ref_nxt;
      pri_res_r     <= pri_res_nxt;
      aux_res_r     <= aux_res_nxt;
      pri_coef_we_r <= pri_coef_we_nxt;
      aux_coef_we_r <= aux_coef_we_nxt;
    end
  end

  // sticky flags
  asf_flag_cell u_primary_ready
  (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (pri_conv_done_i || pri_cal_done_i),
    .ind_clr_i (cal_launch),
    .sw_we_i   (sw_we[asf_pkg::BIT_PRIMARY_READY]),
    .sw_val_i  (sw_val[asf_pkg::BIT_PRIMARY_READY]),
    .flag_o    (primary_ready_flag)
  );

  asf_flag_cell u_aux_ready
  (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (aux_conv_done_i || aux_cal_ok),
    .ind_clr_i (cal_launch),
    .sw_we_i   (sw_we[asf_pkg::BIT_AUX_READY]),
    .sw_val_i  (sw_val[asf_pkg::BIT_AUX_READY]),
    .flag_o    (aux_ready_flag)
  );

  // calibration flag is hardware-set only: software byte writes do not touch it
  asf_flag_cell u_cal_done
  (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (pri_cal_done_i || aux_cal_ok),
    .ind_clr_i (launch),
    .sw_we_i   (1'b0),
    .sw_val_i  (1'b0),
    .flag_o    (cal_done_flag)
  );

  asf_flag_cell u_primary_error
  (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (pri_err_set),
    .ind_clr_i (launch),
    .sw_we_i   (1'b0),
    .sw_val_i  (1'b0),
    .flag_o    (primary_error_flag)
  );

  asf_flag_cell u_aux_error
  (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (aux_err_set),
    .ind_clr_i (launch),
    .sw_we_i   (1'b0),
    .sw_val_i  (1'b0),
    .flag_o    (aux_error_flag)
  );

  // outputs, all from flops
  assign sfr_rdata_o                = rdata_r;
  assign pri_result_o               = pri_res_r;
  assign aux_result_o               = aux_res_r;
  assign pri_coef_we_o              = pri_coef_we_r;
  assign aux_coef_we_o              = aux_coef_we_r;
  assign primary_converter_enable_o = mode_r[asf_pkg::BIT_PRIMARY_ENABLE];
  assign aux_converter_enable_o     = mode_r[asf_pkg::BIT_AUX_ENABLE];
  assign converter_mode_select_o    = mode_r[asf_pkg::MODE_SEL_LSB +: asf_pkg::MODE_SEL_W];
endmodule // asf_status_flags

// file: testbench/asf_status_flags_sva.sv
`timescale 1ns/1ns
// port-level checks of the status flag bank
module asf_status_flags_chk
#(
  parameter int RES_W = 24
)
(
  // clock and reset
  input wire logic             mclk_i,
  input wire logic             rstn_i,
  // register port
  input wire logic [7:0]       sfr_addr_i,
  input wire logic             sfr_wr_i,
  input wire logic [7:0]       sfr_wdata_i,
  input wire logic             sfr_rd_i,
  input wire logic [7:0]       sfr_rdata_o,
  // converter side
  input wire logic             pri_conv_done_i,
  input wire logic             pri_cal_done_i,
  input wire logic             pri_cal_fail_i,
  input wire logic             aux_cal_done_i,
  input wire logic             aux_temp_sel_i,
  input wire logic             primary_reference_pair_bad_i,
  input wire logic [RES_W-1:0] pri_result_o,
  input wire logic             pri_coef_we_o,
  input wire logic             aux_coef_we_o,
  input wire logic             primary_converter_enable_o,
  input wire logic             aux_converter_enable_o,
  input wire logic [2:0]       converter_mode_select_o
);
  logic noref_r;
  logic noref_nxt;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // expected missing-reference level, only meaningful while a converter runs
  always_comb noref_nxt = rstn_i & primary_reference_pair_bad_i &
                          (primary_converter_enable_o | aux_converter_enable_o);
  always_ff @(posedge mclk_i) noref_r <= noref_nxt;
  property p_mode_write;
    sfr_wr_i && sfr_addr_i == 8'hd1 |=> primary_converter_enable_o == $past(sfr_wdata_i[5])
      && aux_converter_enable_o == $past(sfr_wdata_i[4])
      && converter_mode_select_o == $past(sfr_wdata_i[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode outputs wrong");
  property p_noref;
    sfr_rd_i && sfr_addr_i == 8'hd8 |=> sfr_rdata_o[4] == $past(noref_r);
  endproperty
  a_noref: assert property (p_noref) else $error("reference flag wrong");
  property p_forced_ones;
    $changed(pri_result_o) && $past(noref_r) |-> &pri_result_o;
  endproperty
  a_forced_ones: assert property (p_forced_ones) else $error("result not all ones");
  property p_result_cause;
    $changed(pri_result_o) |-> $past(pri_conv_done_i);
  endproperty
  a_result_cause: assert property (p_result_cause) else $error("result moved alone");
  property p_coef_cause;
    pri_coef_we_o |-> $past(pri_cal_done_i) && !$past(pri_cal_fail_i);
  endproperty
  a_coef_cause: assert property (p_coef_cause) else $error("stray coefficient write");
  property p_aux_coef;
    aux_coef_we_o |-> $past(aux_cal_done_i);
  endproperty
  a_aux_coef: assert property (p_aux_coef) else $error("stray aux coefficient");
  property p_temp_block;
    aux_cal_done_i && aux_temp_sel_i |=> !aux_coef_we_o;
  endproperty
  a_temp_block: assert property (p_temp_block) else $error("sensor cal completed");
  property p_unused_bits;
    sfr_rd_i && sfr_addr_i == 8'hd8 |=> sfr_rdata_o[1:0] == 2'h0;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bits set");
endmodule // asf_status_flags_chk
bind asf_status_flags asf_status_flags_chk #(.RES_W(RES_W)) i_chk (.mclk_i, .rstn_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .pri_conv_done_i,
  .pri_cal_done_i, .pri_cal_fail_i, .aux_cal_done_i, .aux_temp_sel_i,
  .primary_reference_pair_bad_i, .pri_result_o, .pri_coef_we_o, .aux_coef_we_o,
  .primary_converter_enable_o, .aux_converter_enable_o, .converter_mode_select_o);

// file: testbench/test_asf_status_flags.sv
`timescale 1ns/1ns
module test_asf_status_flags;
  typedef struct packed {logic aux; logic [7:0] raw; logic [7:0] stat;} asf_row_s;
  logic       mclk_i = 0, rstn_i = 0, wr = 0, rd_s = 0, bw_s = 0, bv = 0, pcv = 0, acv = 0;
  logic       pcd = 0, pcf = 0, acd = 0, acf = 0, ats = 0, bad = 0, pcw, acw, pen, aen;
  logic [7:0] addr = 0, wdat = 0, ba = 0, praw = 0, araw = 0, rdata, pres, ares;
  logic [2:0] msel;
  int         failures = 0, tests_run = 0, cyc = 0;
  // conversions with an in-range value and both saturation ends
  asf_row_s   rows [6] = '{'{0, 8'h5a, 8'h80}, '{0, 8'h00, 8'h88}, '{0, 8'hff, 8'h88},
                           '{1, 8'h33, 8'h40}, '{1, 8'hff, 8'h44}, '{1, 8'h00, 8'h44}};
  asf_status_flags #(.RES_W(8)) i_asf_status_flags (.mclk_i, .rstn_i, .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdat), .sfr_rd_i(rd_s), .sfr_rdata_o(rdata), .bit_addr_i(ba),
    .bit_wr_i(bw_s), .bit_val_i(bv), .pri_conv_done_i(pcv), .pri_cal_done_i(pcd),
    .pri_cal_fail_i(pcf), .pri_raw_i(praw), .aux_conv_done_i(acv), .aux_cal_done_i(acd),
    .aux_cal_fail_i(acf), .aux_temp_sel_i(ats), .aux_raw_i(araw),
    .primary_reference_pair_bad_i(bad), .pri_result_o(pres), .aux_result_o(ares),
    .pri_coef_we_o(pcw), .aux_coef_we_o(acw), .primary_converter_enable_o(pen),
    .aux_converter_enable_o(aen), .converter_mode_select_o(msel));
  always #5 mclk_i = ~mclk_i;
  // hang guard, well above the roughly 150 cycles the run needs
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdat <= d;
    wr <= 1;
    @(posedge mclk_i);
    wr <= 0;
  endtask
  // read data stands until the next read, so it is sampled one edge later
  task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1;
    @(posedge mclk_i);
    rd_s <= 0;
    @(posedge mclk_i);
    chk(rdata & m, e);
  endtask
  // converter event pulse: 0 pri conv, 1 aux conv, 2 pri cal, 3 aux cal; h adds a bit write
  task automatic ev(input int k, input logic [7:0] raw, input logic h, input logic [7:0] a,
                    input logic v);
    @(posedge mclk_i);
    praw <= raw;
    araw <= raw;
    {pcv, acv, pcd, acd} <= 4'h8 >> k;
    {bw_s, ba, bv} <= {h, a, v};
    @(posedge mclk_i);
    {pcv, acv, pcd, acd, bw_s} <= 5'h0;
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1;
    rreg(8'hd1, 8'hff, 8'h08);
    rreg(8'hd8, 8'hff, 8'h00);
    rreg(8'h55, 8'hff, 8'h00);
    $display("reset test done");
    foreach (rows[i])
    begin
      wreg(8'hd8, 8'h00);
      wreg(8'hd1, 8'h31);
      ev(rows[i].aux, rows[i].raw, 0, 0, 0);
      rreg(8'hd8, 8'hff, rows[i].stat);
      chk(rows[i].aux ? ares : pres, rows[i].raw);
    end
    $display("table test done");
    // ready flag held: later results and coefficients are blocked
    wreg(8'hd8, 8'h00);
    ev(0, 8'h21, 0, 0, 0);
    ev(0, 8'h77, 0, 0, 0);
    chk(pres, 8'h21);
    ev(2, 0, 0, 0, 0);
    chk(pcw, 0);
    // calibration launch, success, then failure
    wreg(8'hd1, 8'h34);
    @(posedge mclk_i);
    chk({2'h0, pen, aen, 1'b0, msel}, 8'h34);
    rreg(8'hd8, 8'hff, 8'h00);
    ev(2, 0, 0, 0, 0);
    chk(pcw, 1);
    rreg(8'hd8, 8'hff, 8'ha0);
    wreg(8'hd1, 8'h31);
    rreg(8'hd8, 8'hff, 8'h80);
    wreg(8'hd1, 8'h34);
    pcf <= 1;
    ev(2, 0, 0, 0, 0);
    chk(pcw, 0);
    rreg(8'hd8, 8'h08, 8'h08);
    pcf <= 0;
    // temperature sensor calibration never completes
    wreg(8'hd1, 8'h34);
    ats <= 1;
    ev(3, 0, 0, 0, 0);
    chk(acw, 0);
    rreg(8'hd8, 8'h60, 8'h00);
    ats <= 0;
    ev(3, 0, 0, 0, 0);
    chk(acw, 1);
    rreg(8'hd8, 8'h60, 8'h60);
    $display("calibration test done");
    // missing reference while enabled forces all ones
    wreg(8'hd1, 8'h31);
    wreg(8'hd8, 8'h00);
    bad <= 1;
    rreg(8'hd8, 8'h10, 8'h10);
    ev(0, 8'h12, 0, 0, 0);
    chk(pres, 8'hff);
    rreg(8'hd8, 8'h18, 8'h18);
    bad <= 0;
    rreg(8'hd8, 8'h10, 8'h00);
    // bit writes: hardware set beats a clear in the same cycle
    wreg(8'hd1, 8'h31);
    wreg(8'hd8, 8'h00);
    ev(0, 8'h05, 1, 8'hdf, 0);
    rreg(8'hd8, 8'h80, 8'h80);
    ev(4, 0, 1, 8'hde, 1);
    ev(4, 0, 1, 8'hdb, 1);
    ev(4, 0, 1, 8'hdf, 0);
    rreg(8'hd8, 8'hc8, 8'h40);
    wreg(8'hd1, 8'h00);
    bad <= 1;
    rreg(8'hd8, 8'h10, 8'h00);
    bad <= 0;
    $display("reference and bit test done");
    end_sim();
  end
endmodule // test_asf_status_flags
